// file: design/clbi_top.sv
// Local bus interface: cycle sequencer, status pins, arbitration, interrupt inputs
`timescale 1ns/1ps
`default_nettype none
module clbi_top (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       cyc_valid_i,
   input  wire logic [2:0] cyc_code_i,
   input  wire logic       cyc_hi_byte_i,
   input  wire logic       cyc_addr0_i,
   input  wire logic [1:0] cyc_seg_i,
   input  wire logic       cyc_split_first_i,
   input  wire logic       cyc_inta_first_i,
   input  wire logic       ready_i,
   input  wire logic       instr_last_i,
   input  wire logic       instr_done_i,
   input  wire logic       lock_prefix_i,
   input  wire logic       irq_enable_i,
   input  wire logic       wait_instr_i,
   input  wire logic [1:0] queue_op_i,
   input  wire logic       maskable_irq_i,
   input  wire logic       unmaskable_irq_i,
   input  wire logic       wait_release_i,
   input  wire logic       cpu_reset_i,
   input  wire logic       config_strap_i,
   input  wire logic       bus_req_grant_hi_i,
   input  wire logic       bus_req_grant_lo_i,
   output logic [2:0]      cycle_status_o,
   output logic            cycle_status_oe_o,
   output logic            high_byte_enable_spare_status_o,
   output logic            high_byte_enable_spare_status_oe_o,
   output logic            low_address_bit_o,
   output logic            low_address_bit_oe_o,
   output logic            read_strobe_n_o,
   output logic            read_strobe_n_oe_o,
   output logic            bus_lock_n_o,
   output logic            bus_lock_n_oe_o,
   output logic            mem_io_o,
   output logic            mem_io_oe_o,
   output logic [1:0]      segment_status_o,
   output logic            segment_status_oe_o,
   output logic [1:0]      queue_status_o,
   output logic            bus_req_grant_hi_o,
   output logic            bus_req_grant_hi_oe_o,
   output logic            bus_req_grant_lo_o,
   output logic            bus_req_grant_lo_oe_o,
   output logic            cyc_done_o,
   output logic            hold_ack_o,
   output logic            irq_take_o,
   output logic            nmi_take_o,
   output logic [7:0]      int_type_o,
   output logic            wait_idle_o,
   output logic            restart_o,
   output logic            max_mode_o
);
   clbi_pkg::clbi_bus_t state_q, state_d;
   logic [2:0] code_q, code_d;
   logic       hi_q, hi_d, a0_q, a0_d, split_q, split_d, ack1_q, ack1_d;
   logic [1:0] seg_q, seg_d;
   logic [clbi_pkg::CHANNELS-1:0] pend_q, pend_d, pulse, grant;
   logic       owner_q, owner_d, early_q, early_d, sel, release_ok;
   logic       lock_q, lock_d, max_q, max_d, strap_q, strap_d;
   logic [2:0] rcnt_q, rcnt_d;
   logic       rprev_q, rprev_d, nprev_q, nprev_d, npend_q, npend_d;
   logic       irq_s, nmi_s, test_s, rst_s, drive, accept;
   logic [2:0] status_q, status_d;
   logic       status_oe_q, status_oe_d, bhe_q, bhe_d, pin_oe_q, pin_oe_d;
   logic       a0o_q, a0o_d, rd_n_q, rd_n_d, lock_n_q, lock_n_d, lock_oe_q, lock_oe_d;
   logic       mio_q, mio_d, mio_oe_q, mio_oe_d;
   logic [1:0] sego_q, sego_d, qs_q, qs_d;
   logic       done_q, done_d, hold_q, hold_d, irqt_q, irqt_d, nmit_q, nmit_d;
   logic [7:0] type_q, type_d;
   logic       idle_q, idle_d, restart_q, restart_d;
   logic [clbi_pkg::CHANNELS-1:0] rq_pin_i, rq_pin_o, rq_oe_o;

   clbi_sync #(
      .W (4)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .d_i       ({maskable_irq_i, unmaskable_irq_i, wait_release_i, cpu_reset_i}),
      .q_o       ({irq_s, nmi_s, test_s, rst_s})
   );

   assign rq_pin_i = {bus_req_grant_lo_i, bus_req_grant_hi_i};

   // Index 0 is the higher-priority channel
   for (genvar ch = 0; ch < clbi_pkg::CHANNELS; ch++) begin : g_chan
      clbi_rqgt u_chan (
         .clk_sys_i (clk_sys_i),
         .rst_i     (rst_i),
         .enable_i  (max_q),
         .grant_i   (grant[ch]),
         .pin_i     (rq_pin_i[ch]),
         .pulse_o   (pulse[ch]),
         .pin_o     (rq_pin_o[ch]),
         .pin_oe_o  (rq_oe_o[ch])
      );
   end

   // Bus sequencer, arbitration, lock and reset tracking
   always_comb begin
      state_d = state_q;
      code_d  = code_q;
      hi_d    = hi_q;
      a0_d    = a0_q;
      seg_d   = seg_q;
      split_d = split_q;
      ack1_d  = ack1_q;
      owner_d = owner_q;
      accept  = 1'b0;
      sel     = ~pend_q[0];
      release_ok = early_q & ~split_q & ~ack1_q & ~lock_q;
      case (state_q)
         clbi_pkg::BS_IDLE: begin
            if (|pend_q) begin
               state_d = clbi_pkg::BS_GRANT;
            end else if (cyc_valid_i) begin
               state_d = clbi_pkg::BS_T1;
               accept  = 1'b1;
            end
         end
         clbi_pkg::BS_T1: state_d = clbi_pkg::BS_T2;
         clbi_pkg::BS_T2: state_d = clbi_pkg::BS_T3;
         clbi_pkg::BS_T3, clbi_pkg::BS_TW: begin
            // Ready is used as sampled: the system must present it synchronous
            state_d = ready_i ? clbi_pkg::BS_T4 : clbi_pkg::BS_TW;
         end
         clbi_pkg::BS_T4: begin
            state_d = ((|pend_q) && release_ok) ? clbi_pkg::BS_GRANT : clbi_pkg::BS_IDLE;
         end
         clbi_pkg::BS_GRANT: state_d = clbi_pkg::BS_HOLD;
         clbi_pkg::BS_HOLD: begin
            if (pulse[owner_q]) begin
               state_d = clbi_pkg::BS_DEAD;
            end
         end
         clbi_pkg::BS_DEAD: state_d = clbi_pkg::BS_IDLE;
         default: state_d = clbi_pkg::BS_IDLE;
      endcase
      if (rst_s) begin
         state_d = clbi_pkg::BS_IDLE;
         accept  = 1'b0;
      end
      if (accept) begin
         code_d  = cyc_code_i;
         hi_d    = cyc_hi_byte_i;
         a0_d    = cyc_addr0_i;
         seg_d   = cyc_seg_i;
         split_d = cyc_split_first_i;
         ack1_d  = cyc_inta_first_i;
      end
      grant = '0;
      if (state_d == clbi_pkg::BS_GRANT) begin
         grant[sel] = 1'b1;
         owner_d    = sel;
      end
      // Pulses during the dead clock or the owner's release are not new requests
      pend_d = pend_q & ~grant;
      for (int ch = 0; ch < clbi_pkg::CHANNELS; ch++) begin
         if (pulse[ch] && state_q != clbi_pkg::BS_DEAD
             && !(state_q == clbi_pkg::BS_HOLD && owner_q == ch)) begin
            pend_d[ch] = 1'b1;
         end
      end
      if (rst_s || !max_q) begin
         pend_d = '0;
      end
      early_d = early_q;
      if (state_q == clbi_pkg::BS_IDLE || state_q == clbi_pkg::BS_T4) begin
         early_d = 1'b0;
      end
      if ((|pend_d) && (state_q inside {clbi_pkg::BS_T1, clbi_pkg::BS_T2, clbi_pkg::BS_T3})) begin
         early_d = 1'b1;
      end
      lock_d = lock_q;
      if (instr_done_i) begin
         lock_d = 1'b0;
      end
      if (lock_prefix_i) begin
         lock_d = 1'b1;
      end
      if (rst_s) begin
         lock_d = 1'b0;
      end
      rcnt_d  = rst_s ? ((rcnt_q < clbi_pkg::RST_MIN_CLK) ? rcnt_q + 3'h1 : rcnt_q) : 3'h0;
      rprev_d = rst_s;
      // Strap is caught after the system reset and again while the cpu reset is high
      strap_d = 1'b1;
      max_d   = (!strap_q || rst_s) ? (config_strap_i == clbi_pkg::STRAP_MAX) : max_q;
   end

   // Pin images, computed from the next state so every pin leaves a flop
   always_comb begin
      drive       = (state_d != clbi_pkg::BS_GRANT) && (state_d != clbi_pkg::BS_HOLD);
      pin_oe_d    = drive;
      status_oe_d = drive & max_d;
      status_d    = clbi_pkg::CS_PASSIVE;
      if (state_d == clbi_pkg::BS_T1 || state_d == clbi_pkg::BS_T2) begin
         status_d = code_d;
      end
      a0o_d = a0_d;
      bhe_d = 1'b1;
      if (state_d == clbi_pkg::BS_T1) begin
         bhe_d = ~(hi_d | ack1_d);
      end else if (state_d == clbi_pkg::BS_T2 || state_d == clbi_pkg::BS_T3
                   || state_d == clbi_pkg::BS_TW || state_d == clbi_pkg::BS_T4) begin
         bhe_d = clbi_pkg::SPARE_BIT;
      end
      // Strobe falls only on the edge that opens the second state, as the byte enable pin turns to spare status
      rd_n_d    = ~(clbi_pkg::in_strobe(state_d) & clbi_pkg::is_read(code_d));
      lock_n_d  = ~lock_d;
      lock_oe_d = drive & max_d;
      mio_d     = code_d[clbi_pkg::CS_MEM_BIT];
      mio_oe_d  = drive & ~max_d;
      sego_d    = (state_d == clbi_pkg::BS_IDLE) ? clbi_pkg::SEG_CODE : seg_d;
      qs_d      = max_q ? queue_op_i : clbi_pkg::QS_NONE;
      done_d    = (state_d == clbi_pkg::BS_T4);
      hold_d    = (state_d == clbi_pkg::BS_HOLD);
      nprev_d   = nmi_s;
      // A rising edge in the taking cycle stays pending for the next instruction
      npend_d   = (npend_q & ~instr_last_i) | (nmi_s & ~nprev_q) | (npend_q & nmi_s & ~nprev_q);
      nmit_d    = instr_last_i & npend_q;
      irqt_d    = instr_last_i & irq_s & irq_enable_i & ~npend_q;
      type_d    = nmit_d ? clbi_pkg::NMI_TYPE : clbi_pkg::TYPE_NONE;
      idle_d    = wait_instr_i & test_s;
      restart_d = rprev_q & ~rst_s & (rcnt_q == clbi_pkg::RST_MIN_CLK);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= clbi_pkg::BS_IDLE;
         code_q <= clbi_pkg::CS_PASSIVE;
         {hi_q, a0_q, split_q, ack1_q, owner_q, early_q, lock_q} <= '0;
         seg_q <= clbi_pkg::SEG_CODE;
         pend_q <= '0;
         {max_q, strap_q, rprev_q, nprev_q, npend_q} <= '0;
         rcnt_q <= 3'h0;
         status_q <= clbi_pkg::CS_PASSIVE;
         {status_oe_q, pin_oe_q, lock_oe_q, mio_oe_q} <= '0;
         {bhe_q, rd_n_q, lock_n_q} <= 3'h7;
         {a0o_q, mio_q, done_q, hold_q, irqt_q, nmit_q, idle_q, restart_q} <= '0;
         sego_q <= clbi_pkg::SEG_CODE;
         qs_q <= clbi_pkg::QS_NONE;
         type_q <= clbi_pkg::TYPE_NONE;
      end else begin
         state_q <= state_d;
         code_q <= code_d;
         {hi_q, a0_q, split_q, ack1_q} <= {hi_d, a0_d, split_d, ack1_d};
         {owner_q, early_q, lock_q} <= {owner_d, early_d, lock_d};
         seg_q <= seg_d;
         pend_q <= pend_d;
         {max_q, strap_q, rprev_q, nprev_q, npend_q} <= {max_d, strap_d, rprev_d, nprev_d, npend_d};
         rcnt_q <= rcnt_d;
         status_q <= status_d;
         {status_oe_q, pin_oe_q, lock_oe_q, mio_oe_q} <= {status_oe_d, pin_oe_d, lock_oe_d, mio_oe_d};
         {bhe_q, rd_n_q, lock_n_q} <= {bhe_d, rd_n_d, lock_n_d};
         {a0o_q, mio_q, done_q, hold_q} <= {a0o_d, mio_d, done_d, hold_d};
         {irqt_q, nmit_q, idle_q, restart_q} <= {irqt_d, nmit_d, idle_d, restart_d};
         sego_q <= sego_d;
         qs_q <= qs_d;
         type_q <= type_d;
      end
   end

   assign cycle_status_o                     = status_q;
   assign cycle_status_oe_o                  = status_oe_q;
   assign high_byte_enable_spare_status_o    = bhe_q;
   assign high_byte_enable_spare_status_oe_o = pin_oe_q;
   assign low_address_bit_o                  = a0o_q;
   assign low_address_bit_oe_o               = pin_oe_q;
   assign read_strobe_n_o                    = rd_n_q;
   assign read_strobe_n_oe_o                 = pin_oe_q;
   assign bus_lock_n_o                       = lock_n_q;
   assign bus_lock_n_oe_o                    = lock_oe_q;
   assign mem_io_o                           = mio_q;
   assign mem_io_oe_o                        = mio_oe_q;
   assign segment_status_o                   = sego_q;
   assign segment_status_oe_o                = pin_oe_q;
   assign queue_status_o                     = qs_q;
   assign bus_req_grant_hi_o                 = rq_pin_o[0];
   assign bus_req_grant_hi_oe_o              = rq_oe_o[0];
   assign bus_req_grant_lo_o                 = rq_pin_o[1];
   assign bus_req_grant_lo_oe_o              = rq_oe_o[1];
   assign cyc_done_o                         = done_q;
   assign hold_ack_o                         = hold_q;
   assign irq_take_o                         = irqt_q;
   assign nmi_take_o                         = nmit_q;
   assign int_type_o                         = type_q;
   assign wait_idle_o                        = idle_q;
   assign restart_o                          = restart_q;
   assign max_mode_o                         = max_q;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   byte_lane_a: assert property ((state_q == clbi_pkg::BS_T1) |->
      (bhe_q == ~(hi_q | ack1_q)) && (low_address_bit_o == a0_q))
      else $error("byte lane encoding wrong in first state");
   spare_phase_a: assert property ((state_q inside {clbi_pkg::BS_T2, clbi_pkg::BS_T4}) |->
      (bhe_q == clbi_pkg::SPARE_BIT) && pin_oe_q)
      else $error("spare status not shown after enable phase");
   read_strobe_a: assert property ((state_q == clbi_pkg::BS_HOLD) |->
      !read_strobe_n_oe_o && !high_byte_enable_spare_status_oe_o)
      else $error("bus pins driven during hold");
   wait_insert_a: assert property ((state_q == clbi_pkg::BS_T3 && !ready_i && !rst_s) |=>
      (state_q == clbi_pkg::BS_TW) && !read_strobe_n_o == clbi_pkg::is_read(code_q))
      else $error("wait state not inserted");
   status_end_a: assert property ($rose(state_q == clbi_pkg::BS_T1) |->
      (status_q == code_q) ##2 (status_q == clbi_pkg::CS_PASSIVE))
      else $error("status timing wrong");
   grant_pulse_a: assert property ($rose(state_q == clbi_pkg::BS_GRANT) |->
      (|rq_oe_o) && !hold_ack_o ##1 hold_ack_o && !(|rq_oe_o))
      else $error("grant pulse or hold entry wrong");
   dead_clock_a: assert property ((state_q == clbi_pkg::BS_DEAD) |->
      !hold_ack_o ##1 (state_q != clbi_pkg::BS_GRANT))
      else $error("no idle clock after exchange");
   locked_keep_a: assert property ((state_q == clbi_pkg::BS_T4 && (lock_q || split_q)) |=>
      (state_q != clbi_pkg::BS_GRANT))
      else $error("bus released under lock or split");
   idle_release_a: assert property ((state_q == clbi_pkg::BS_IDLE && (|pend_q) && !rst_s) |=>
      (state_q == clbi_pkg::BS_GRANT) ##1 hold_ack_o)
      else $error("idle request not released next clock");
   nmi_take_a: assert property ((npend_q && instr_last_i) |=>
      nmi_take_o && (int_type_o == clbi_pkg::NMI_TYPE) && !irq_take_o)
      else $error("unmaskable request not taken");
   irq_mask_a: assert property ((instr_last_i && !irq_enable_i) |=> !irq_take_o)
      else $error("masked request taken");
   lock_hold_a: assert property ((lock_prefix_i && !rst_s) |=> !bus_lock_n_o)
      else $error("lock not asserted after prefix");
   queue_next_a: assert property (max_q |=> (queue_status_o == $past(queue_op_i)))
      else $error("queue status not one clock later");

   read_wait_c: cover property ((state_q == clbi_pkg::BS_TW) ##1 (state_q == clbi_pkg::BS_T4));
   exchange_c: cover property (hold_ack_o ##[1:20] (state_q == clbi_pkg::BS_DEAD));
   nmi_c: cover property (nmi_take_o);
   lock_c: cover property (!bus_lock_n_o && (state_q == clbi_pkg::BS_T4));
endmodule
`default_nettype wire

// file: design/clbi_pkg.sv
// Shared constants, state type and decode functions of the local bus interface
package clbi_pkg;
   localparam logic [2:0] CS_INTA    = 3'h0;
   localparam logic [2:0] CS_IO_RD   = 3'h1;
   localparam logic [2:0] CS_IO_WR   = 3'h2;
   localparam logic [2:0] CS_HALT    = 3'h3;
   localparam logic [2:0] CS_FETCH   = 3'h4;
   localparam logic [2:0] CS_MEM_RD  = 3'h5;
   localparam logic [2:0] CS_MEM_WR  = 3'h6;
   localparam logic [2:0] CS_PASSIVE = 3'h7;
   localparam int         CS_MEM_BIT = 2;
   localparam logic [1:0] SEG_CODE   = 2'h2;
   localparam logic [1:0] QS_NONE    = 2'h0;
   localparam logic       SPARE_BIT  = 1'b0;
   localparam logic       STRAP_MAX  = 1'b0;
   localparam logic [7:0] NMI_TYPE   = 8'h02;
   localparam logic [7:0] TYPE_NONE  = 8'h00;
   localparam logic [2:0] RST_MIN_CLK = 3'h4;
   localparam int         CHANNELS   = 2;

   typedef enum logic [3:0] {
      BS_IDLE, BS_T1, BS_T2, BS_T3, BS_TW, BS_T4, BS_GRANT, BS_HOLD, BS_DEAD
   } clbi_bus_t;

   function automatic logic is_read(input logic [2:0] code);
      return (code == CS_IO_RD) || (code == CS_FETCH) || (code == CS_MEM_RD);
   endfunction

   function automatic logic in_strobe(input clbi_bus_t st);
      return (st == BS_T2) || (st == BS_T3) || (st == BS_TW);
   endfunction
endpackage

// file: design/clbi_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module clbi_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = d_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_o = sync_q;
endmodule
`default_nettype wire

// file: design/clbi_rqgt.sv
// One request/grant channel: pulse detector and grant pulse driver
`timescale 1ns/1ps
`default_nettype none
module clbi_rqgt (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic enable_i,
   input  wire logic grant_i,
   input  wire logic pin_i,
   output logic      pulse_o,
   output logic      pin_o,
   output logic      pin_oe_o
);
   logic prev_q;
   logic prev_d;
   logic pulse_q;
   logic pulse_d;
   logic oe_q;
   logic oe_d;
   logic pin_q;
   logic pin_d;

   // Our own grant pulse must not be read back as a request
   always_comb begin
      prev_d  = pin_i | oe_q;
      pulse_d = enable_i & prev_q & ~pin_i & ~oe_q;
      oe_d    = grant_i;
      pin_d   = ~grant_i;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         prev_q  <= 1'b1;
         pulse_q <= 1'b0;
         oe_q    <= 1'b0;
         pin_q   <= 1'b1;
      end else begin
         prev_q  <= prev_d;
         pulse_q <= pulse_d;
         oe_q    <= oe_d;
         pin_q   <= pin_d;
      end
   end

   assign pulse_o  = pulse_q;
   assign pin_o    = pin_q;
   assign pin_oe_o = oe_q;
endmodule
`default_nettype wire

// file: test/clbi_far_model.sv
// Far side: addressed device giving ready with wait states, two masters on pulled-up pins
`timescale 1ns/1ps
`default_nettype none
module clbi_far_model (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic [2:0] cycle_status_i,
   input  wire logic [1:0] waits_i,
   input  wire logic [1:0] pulse_i,
   input  wire logic [1:0] gnt_i,
   output logic            ready_o,
   output logic [1:0]      pin_o
);
   logic [1:0] cnt_q;
   logic [1:0] drv_q;
   logic [2:0] st_q;
   // Ready comes from a flop, so it is already synchronous to the clock
   assign ready_o = (cnt_q == 2'h0);
   // Pull-up wins unless a party pulls low, so a released pin reads high
   assign pin_o = ~(drv_q | gnt_i);
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 2'h0;
         drv_q <= 2'h0;
         st_q  <= 3'h7;
      end else begin
         st_q  <= cycle_status_i;
         drv_q <= pulse_i;
         if (st_q == 3'h7 && cycle_status_i != 3'h7) begin
            cnt_q <= waits_i;
         end else if (cycle_status_i == 3'h7 && cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/clbi_top_test.sv
// Self-checking bench of the local bus interface against its far side model
`timescale 1ns/1ps
`default_nettype none
module clbi_top_test;
   logic clk_sys_i, rst_i, cyc_valid_i, cyc_hi_byte_i, cyc_addr0_i, ready_i, instr_last_i;
   logic instr_done_i, lock_prefix_i, irq_enable_i, wait_instr_i, maskable_irq_i;
   logic unmaskable_irq_i, wait_release_i, cpu_reset_i, bus_req_grant_hi_i, bus_req_grant_lo_i;
   logic [2:0] cyc_code_i, cycle_status_o;
   logic [1:0] cyc_seg_i, queue_op_i, segment_status_o, queue_status_o, waits, pulse, pin, gnt;
   logic cycle_status_oe_o, high_byte_enable_spare_status_o, high_byte_enable_spare_status_oe_o;
   logic low_address_bit_o, read_strobe_n_o, read_strobe_n_oe_o, bus_lock_n_o, cyc_done_o;
   logic bus_req_grant_hi_o, bus_req_grant_hi_oe_o, bus_req_grant_lo_o, bus_req_grant_lo_oe_o;
   logic hold_ack_o, irq_take_o, nmi_take_o, wait_idle_o, restart_o, max_mode_o;
   logic [7:0] int_type_o;
   logic cyc_split_first_i, cyc_inta_first_i, config_strap_i, mem_io_o, mem_io_oe_o;
   logic low_address_bit_oe_o, bus_lock_n_oe_o, segment_status_oe_o;
   int fails, checks_done, n;
   clbi_top i_clbi_top (.clk_sys_i, .rst_i, .cyc_valid_i, .cyc_code_i, .cyc_hi_byte_i,
      .cyc_addr0_i, .cyc_seg_i, .cyc_split_first_i, .cyc_inta_first_i, .ready_i,
      .instr_last_i, .instr_done_i, .lock_prefix_i, .irq_enable_i, .wait_instr_i, .queue_op_i,
      .maskable_irq_i, .unmaskable_irq_i, .wait_release_i, .cpu_reset_i, .config_strap_i,
      .bus_req_grant_hi_i, .bus_req_grant_lo_i, .cycle_status_o, .cycle_status_oe_o,
      .high_byte_enable_spare_status_o, .high_byte_enable_spare_status_oe_o, .low_address_bit_o,
      .low_address_bit_oe_o, .read_strobe_n_o, .read_strobe_n_oe_o, .bus_lock_n_o,
      .bus_lock_n_oe_o, .mem_io_o, .mem_io_oe_o, .segment_status_o, .segment_status_oe_o,
      .queue_status_o, .bus_req_grant_hi_o, .bus_req_grant_hi_oe_o, .bus_req_grant_lo_o,
      .bus_req_grant_lo_oe_o, .cyc_done_o, .hold_ack_o, .irq_take_o, .nmi_take_o, .int_type_o,
      .wait_idle_o, .restart_o, .max_mode_o);
   clbi_far_model i_clbi_far_model (.clk_sys_i, .rst_i, .cycle_status_i(cycle_status_o),
      .waits_i(waits), .pulse_i(pulse), .gnt_i(gnt), .ready_o(ready_i), .pin_o(pin));
   assign gnt = {bus_req_grant_lo_oe_o & ~bus_req_grant_lo_o,
                 bus_req_grant_hi_oe_o & ~bus_req_grant_hi_o};
   assign bus_req_grant_hi_i = pin[0];
   assign bus_req_grant_lo_i = pin[1];
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic pulse_in(input logic [2:0] sel);
      @(posedge clk_sys_i);
      {instr_last_i, lock_prefix_i, instr_done_i} <= sel;
      @(posedge clk_sys_i);
      {instr_last_i, lock_prefix_i, instr_done_i} <= 3'h0;
      @(negedge clk_sys_i);
   endtask
   task automatic bus_cycle(input logic [2:0] code, input logic [1:0] w);
      logic hi;
      logic a0;
      logic ia;
      logic [1:0] sg;
      hi = 1'($urandom);
      a0 = 1'($urandom);
      ia = (code == 3'h0) && 1'($urandom);
      sg = 2'($urandom);
      @(posedge clk_sys_i);
      waits <= w;
      cyc_valid_i <= 1'b1;
      cyc_code_i <= code;
      cyc_hi_byte_i <= hi;
      cyc_addr0_i <= a0;
      cyc_seg_i <= sg;
      cyc_inta_first_i <= ia;
      cyc_split_first_i <= a0 & 1'($urandom);
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(cycle_status_o, code);
      chk({high_byte_enable_spare_status_o, low_address_bit_o}, {~(hi | ia), a0});
      chk(mem_io_o, code[2]);
      chk(segment_status_o, sg);
      @(negedge clk_sys_i);
      chk(high_byte_enable_spare_status_o, 8'h00);
      chk(read_strobe_n_o, !(code == 3'h1 || code == 3'h4 || code == 3'h5));
      @(negedge clk_sys_i);
      chk(cycle_status_o, 8'h07);
      n = 3;
      while (cyc_done_o !== 1'b1 && n < 12) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(n, 4 + w);
      @(posedge clk_sys_i);
      cyc_valid_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic exchange(input int ch, input logic [1:0] req);
      @(posedge clk_sys_i);
      pulse <= req;
      @(posedge clk_sys_i);
      pulse <= 2'h0;
      for (n = 0; gnt[ch] !== 1'b1 && n < 8; n++) @(negedge clk_sys_i);
      chk(gnt, 8'h1 << ch);
      @(negedge clk_sys_i);
      chk({hold_ack_o, gnt[ch]}, 8'h2);
      chk({cycle_status_oe_o, high_byte_enable_spare_status_oe_o, read_strobe_n_oe_o}, 0);
      chk({low_address_bit_oe_o, segment_status_oe_o, bus_lock_n_oe_o}, 0);
      repeat (3) @(posedge clk_sys_i);
      pulse <= 2'h1 << ch;
      @(posedge clk_sys_i);
      pulse <= 2'h0;
      for (n = 0; cycle_status_oe_o !== 1'b1 && n < 6; n++) @(negedge clk_sys_i);
      chk({cycle_status_oe_o, hold_ack_o}, 8'h2);
      repeat (2) @(posedge clk_sys_i);
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      {cyc_valid_i, cyc_hi_byte_i, cyc_addr0_i, instr_last_i, instr_done_i, lock_prefix_i} = '0;
      {irq_enable_i, wait_instr_i, maskable_irq_i, unmaskable_irq_i, wait_release_i} = '0;
      {cpu_reset_i, cyc_code_i, cyc_seg_i, queue_op_i, waits, pulse, fails, checks_done} = '0;
      {cyc_split_first_i, cyc_inta_first_i, config_strap_i} = '0;
      rst_i = 1'b1;
      n = $urandom(71);
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk(max_mode_o, 8'h01);
      for (int c = 0; c < 7; c++) bus_cycle(3'(c), 2'($urandom_range(2)));
      repeat (6) bus_cycle(3'($urandom_range(6)), 2'($urandom_range(3)));
      exchange(1, 2'h2);
      exchange(0, 2'h3);
      maskable_irq_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      pulse_in(3'h4);
      chk(irq_take_o, 8'h00);
      irq_enable_i <= 1'b1;
      pulse_in(3'h4);
      chk(irq_take_o, 8'h01);
      maskable_irq_i <= 1'b0;
      unmaskable_irq_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      pulse_in(3'h4);
      chk({nmi_take_o, int_type_o}, 9'h102);
      {wait_instr_i, wait_release_i} <= 2'h3;
      repeat (4) @(negedge clk_sys_i);
      chk(wait_idle_o, 8'h01);
      wait_release_i <= 1'b0;
      repeat (4) @(negedge clk_sys_i);
      chk(wait_idle_o, 8'h00);
      repeat (4) begin
         queue_op_i <= 2'($urandom);
         @(negedge clk_sys_i);
         chk(queue_status_o, queue_op_i);
      end
      pulse_in(3'h2);
      repeat (3) @(negedge clk_sys_i);
      chk(bus_lock_n_o, 8'h00);
      pulse_in(3'h1);
      chk(bus_lock_n_o, 8'h01);
      // Strap is taken again while the cpu reset is high: visit minimum mode once
      {cpu_reset_i, config_strap_i} <= 2'h3;
      repeat (6) @(negedge clk_sys_i);
      chk({max_mode_o, mem_io_oe_o, bus_lock_n_oe_o, cycle_status_oe_o}, 8'h04);
      chk(queue_status_o, 8'h00);
      @(posedge clk_sys_i);
      {cpu_reset_i, config_strap_i} <= 2'h0;
      for (n = 0; restart_o !== 1'b1 && n < 8; n++) @(negedge clk_sys_i);
      chk(restart_o, 8'h01);
      chk(max_mode_o, 8'h01);
      stop_test();
   end
endmodule
`default_nettype wire
